// ===== pih_defs.vh
// Purpose: Shared constants for the programmable interrupt host interface
// Assumes: Included by bare name from the top-level design file only
// Notes: Definitions only; bit positions refer to the 8-bit command byte

`ifndef PIH_DEFS_VH
`define PIH_DEFS_VH

// ***************************************************************
// Command byte field positions
// ***************************************************************
`define PIH_INIT_FLAG_BIT 4
`define PIH_INIT_LEVEL_BIT 3
`define PIH_INIT_SINGLE_BIT 1
`define PIH_INIT_NEED4_BIT 0
`define PIH_OPT_BUFFERED_BIT 3
`define PIH_OPT_BUFMASTER_BIT 2
`define PIH_OPT_AUTOEND_BIT 1
`define PIH_OP_SELECT_BIT 3
`define PIH_OP_END_BIT 5
`define PIH_OP_SPECIFIC_BIT 6
`define PIH_OP_POLL_BIT 2
`define PIH_OP_READSEL_BIT 1
`define PIH_OP_READISR_BIT 0

// ***************************************************************
// Reset and initial values
// ***************************************************************
`define PIH_MASK_RESET 8'hFF
`define PIH_MASK_INIT 8'h00
`define PIH_BASE_RESET 5'h00
`define PIH_CASCADE_RESET 8'h00
`define PIH_SPURIOUS_LEVEL 3'h7
`define PIH_DATA_RESET 8'h00
`define PIH_ID_RESET 3'h0

`endif

// ===== pih_req_sync.v
// Purpose: Two-stage synchroniser for the asynchronous request lines
// Assumes: One clock; request sources are not related to it
// Notes: Only the second stage leaves this module

`timescale 1ns/1ps
`default_nettype none

module pih_req_sync #(
    parameter WIDTH = 8
) (
    input wire clock_in,
    input wire reset_n_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    // ***************************************************************
    // Synchroniser stages
    // ***************************************************************
    reg [WIDTH-1:0] meta;

    // First stage feeds only the second; nothing else may look at it
    always @(posedge clock_in) begin
        if (!reset_n_in) begin
            meta <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

`default_nettype wire

// ===== pih_top.v
// Purpose: Eight-level programmable interrupt controller, host pin side
// Assumes: Host pins are synchronous to clock_in; strobes one cycle long
// Notes: Two-pulse acknowledge; fixed priority, level 0 highest
//
// The strobed register port and the placing of the registers are this design's own decisions.

`timescale 1ns/1ps
`default_nettype none

`include "pih_defs.vh"

// Function
// - Word select picks command word and status
// - Register access only while device selected
// - Acknowledge pulses work without device select
// - Acknowledge pulses put vector on data bus
// - Selected write strobe accepts command word
// - Selected read strobe drives status out
// - Level mode: high level means pending
// - Master drives cascade out, slave reads in
// - Cascade drive flag low only when valid
// - Buffered mode steers transceivers via buffer control
// - Unbuffered: strap high master, low slave
// - Buffer drive flag low only when valid
// - Data valid high only with valid data
// - Interrupt output high on valid request
// - Eight request levels with fixed priorities
// - Cascade one master with slaves, 64 levels
// - Each request maskable; masked never interrupts
// - Interrupt only above in-service priority
module pih_top (
    input wire clock_in,
    input wire reset_n_in,
    input wire word_select_in,
    input wire device_select_low_in,
    input wire write_strobe_low_in,
    input wire read_strobe_low_in,
    input wire [7:0] data_in_bus_in,
    input wire acknowledge_pulse_low_in,
    input wire [7:0] request_lines_in,
    input wire [2:0] cascade_id_in,
    input wire master_strap_in,
    output reg [7:0] data_out_bus_out,
    output reg data_out_valid_out,
    output reg interrupt_out,
    output reg [2:0] cascade_id_out,
    output reg cascade_out_drive_low_out,
    output reg buffer_ctrl_out,
    output reg buffer_ctrl_drive_low_out
);

    // ***************************************************************
    // Initialisation sequence states
    // ***************************************************************
    localparam [1:0] ST_BASE = 2'h0;
    localparam [1:0] ST_CASCADE = 2'h1;
    localparam [1:0] ST_OPTIONS = 2'h2;
    localparam [1:0] ST_READY = 2'h3;

    // ***************************************************************
    // Declarations
    // ***************************************************************
    wire [7:0] req_sync;
    wire [7:0] irr;
    wire [7:0] edge_clear;
    reg [7:0] isr;
    reg [7:0] next_isr;
    reg [7:0] imr;
    reg [4:0] vec_base;
    reg [7:0] cascade_cfg;
    reg [1:0] init_state;
    reg level_mode;
    reg single_mode;
    reg need_options;
    reg auto_end;
    reg buffered;
    reg buf_master;
    reg read_isr;
    reg poll_armed;
    reg strap;
    reg ack_prev;
    reg ack_phase;
    reg ack_hit;
    reg ack_cascaded;
    reg [2:0] ack_level;
    reg [7:0] next_data;
    reg next_valid;

    // ***************************************************************
    // Request synchronisers
    // ***************************************************************
    // Keeps metastability away from edge detection and priority
    pih_req_sync #(
        .WIDTH(8)
    ) u_req_sync (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .async_in(request_lines_in),
        .sync_out(req_sync)
    );

    // ***************************************************************
    // Host port decode
    // ***************************************************************
    // Every access is gated by device select; acknowledge is not
    wire wr_take = ~device_select_low_in & ~write_strobe_low_in;
    wire rd_take = ~device_select_low_in & ~read_strobe_low_in & write_strobe_low_in;
    wire init_wr = wr_take & ~word_select_in & data_in_bus_in[`PIH_INIT_FLAG_BIT];
    wire ready = (init_state == ST_READY);
    wire op_wr = wr_take & ~word_select_in & ~data_in_bus_in[`PIH_INIT_FLAG_BIT] & ready;
    wire sel_wr = op_wr & data_in_bus_in[`PIH_OP_SELECT_BIT];
    wire end_wr = op_wr & ~data_in_bus_in[`PIH_OP_SELECT_BIT] & data_in_bus_in[`PIH_OP_END_BIT];
    wire ack_edge = ack_prev & ~acknowledge_pulse_low_in;
    wire ack_first = ack_edge & ~ack_phase;
    wire ack_second = ack_edge & ack_phase;

    // Role comes from the strap unless buffered mode borrows that pin
    wire is_master = buffered ? buf_master : strap;
    wire own_bus = single_mode | is_master;
    wire id_match = (cascade_id_in == cascade_cfg[2:0]);

    // ***************************************************************
    // Priority resolution
    // ***************************************************************
    // Returns {found, index} of the lowest set bit (highest priority)
    function [3:0] first_set;
        input [7:0] v;
        integer k;
        begin
            first_set = 4'h0;
            for (k = 7; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    first_set = {1'b1, k[2:0]};
                end
            end
        end
    endfunction

    wire [7:0] pend = irr & ~imr;
    wire [3:0] pend_first = first_set(pend);
    wire [3:0] isr_first = first_set(isr);
    // New request must beat whatever is being serviced
    wire req_wins = pend_first[3] & (~isr_first[3] | (pend_first[2:0] < isr_first[2:0]));

    // Master and single parts commit at the first pulse; a slave waits
    // for the second, when the master's cascade code has settled
    wire poll_take = rd_take & poll_armed;
    wire commit_set = (ack_first & own_bus & req_wins)
                      | (ack_second & ~own_bus & ack_hit & id_match)
                      | (poll_take & req_wins);
    wire [2:0] commit_level = (ack_second & ~own_bus) ? ack_level : pend_first[2:0];

    // ***************************************************************
    // Per-level request capture
    // ***************************************************************
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_req
            reg prev;
            reg seen;
            assign edge_clear[i] = commit_set & (commit_level == i);
            // A rise in the clearing cycle is kept, not lost
            always @(posedge clock_in) begin
                if (!reset_n_in) begin
                    prev <= 1'b0;
                    seen <= 1'b0;
                end else begin
                    prev <= req_sync[i];
                    if (init_wr) begin
                        seen <= 1'b0;
                    end else if (req_sync[i] & ~prev) begin
                        seen <= 1'b1;
                    end else if (edge_clear[i] | ~req_sync[i]) begin
                        seen <= 1'b0;
                    end
                end
            end
            // Edge mode also needs the line still high
            assign irr[i] = level_mode ? req_sync[i] : (seen & req_sync[i]);
        end
    endgenerate

    // ***************************************************************
    // Configuration and initialisation sequence
    // ***************************************************************
    always @(posedge clock_in) begin
        if (!reset_n_in) begin
            init_state <= ST_READY;
            level_mode <= 1'b0;
            single_mode <= 1'b1;
            need_options <= 1'b0;
            auto_end <= 1'b0;
            buffered <= 1'b0;
            buf_master <= 1'b0;
            vec_base <= `PIH_BASE_RESET;
            cascade_cfg <= `PIH_CASCADE_RESET;
            imr <= `PIH_MASK_RESET;
            read_isr <= 1'b0;
            poll_armed <= 1'b0;
        end else if (init_wr) begin
            // Start of initialisation wipes mask and options
            init_state <= ST_BASE;
            level_mode <= data_in_bus_in[`PIH_INIT_LEVEL_BIT];
            single_mode <= data_in_bus_in[`PIH_INIT_SINGLE_BIT];
            need_options <= data_in_bus_in[`PIH_INIT_NEED4_BIT];
            auto_end <= 1'b0;
            buffered <= 1'b0;
            buf_master <= 1'b0;
            imr <= `PIH_MASK_INIT;
            read_isr <= 1'b0;
            poll_armed <= 1'b0;
        end else if (wr_take & word_select_in) begin
            // Word select high steps the sequence or loads the mask
            case (init_state)
                ST_BASE: begin
                    vec_base <= data_in_bus_in[7:3];
                    if (!single_mode) begin
                        init_state <= ST_CASCADE;
                    end else if (need_options) begin
                        init_state <= ST_OPTIONS;
                    end else begin
                        init_state <= ST_READY;
                    end
                end
                ST_CASCADE: begin
                    // Master: slave map; slave: own code in low bits
                    cascade_cfg <= data_in_bus_in;
                    init_state <= need_options ? ST_OPTIONS : ST_READY;
                end
                ST_OPTIONS: begin
                    buffered <= data_in_bus_in[`PIH_OPT_BUFFERED_BIT];
                    buf_master <= data_in_bus_in[`PIH_OPT_BUFMASTER_BIT];
                    auto_end <= data_in_bus_in[`PIH_OPT_AUTOEND_BIT];
                    init_state <= ST_READY;
                end
                ST_READY: begin
                    imr <= data_in_bus_in;
                end
                default: begin
                    init_state <= ST_READY;
                end
            endcase
        end else if (sel_wr) begin
            if (data_in_bus_in[`PIH_OP_READSEL_BIT]) begin
                read_isr <= data_in_bus_in[`PIH_OP_READISR_BIT];
            end
            poll_armed <= data_in_bus_in[`PIH_OP_POLL_BIT];
        end else if (rd_take) begin
            // A poll lasts for exactly one following read
            poll_armed <= 1'b0;
        end
    end

    // ***************************************************************
    // In-service register
    // ***************************************************************
    // End command clears first so a same-cycle acknowledge still sets
    always @* begin
        next_isr = isr;
        if (end_wr) begin
            if (data_in_bus_in[`PIH_OP_SPECIFIC_BIT]) begin
                next_isr[data_in_bus_in[2:0]] = 1'b0;
            end else if (isr_first[3]) begin
                next_isr[isr_first[2:0]] = 1'b0;
            end
        end
        if (commit_set) begin
            next_isr[commit_level] = 1'b1;
        end
        if (auto_end & ack_second) begin
            next_isr[ack_level] = 1'b0;
        end
    end

    always @(posedge clock_in) begin
        if (!reset_n_in) begin
            isr <= 8'h00;
        end else if (init_wr) begin
            isr <= 8'h00;
        end else begin
            isr <= next_isr;
        end
    end

    // ***************************************************************
    // Acknowledge sequence and cascade bus
    // ***************************************************************
    always @(posedge clock_in) begin
        if (!reset_n_in) begin
            ack_prev <= 1'b1;
            ack_phase <= 1'b0;
            ack_hit <= 1'b0;
            ack_cascaded <= 1'b0;
            ack_level <= `PIH_SPURIOUS_LEVEL;
            strap <= 1'b1;
            cascade_id_out <= `PIH_ID_RESET;
            cascade_out_drive_low_out <= 1'b1;
        end else begin
            ack_prev <= acknowledge_pulse_low_in;
            strap <= master_strap_in;
            if (ack_first) begin
                // Independent of device select
                ack_phase <= 1'b1;
                if (own_bus) begin
                    ack_hit <= req_wins;
                    ack_level <= req_wins ? pend_first[2:0] : `PIH_SPURIOUS_LEVEL;
                    ack_cascaded <= is_master & ~single_mode & req_wins
                                    & cascade_cfg[pend_first[2:0]];
                    if (is_master & ~single_mode & req_wins & cascade_cfg[pend_first[2:0]]) begin
                        cascade_id_out <= pend_first[2:0];
                        cascade_out_drive_low_out <= 1'b0;
                    end
                end else begin
                    // Slave keeps its choice until the code arrives
                    ack_hit <= req_wins;
                    ack_level <= req_wins ? pend_first[2:0] : `PIH_SPURIOUS_LEVEL;
                    ack_cascaded <= 1'b0;
                end
            end else if (ack_second) begin
                ack_phase <= 1'b0;
                ack_cascaded <= 1'b0;
                cascade_id_out <= `PIH_ID_RESET;
                cascade_out_drive_low_out <= 1'b1;
            end
        end
    end

    // ***************************************************************
    // Output data bus
    // ***************************************************************
    // Reads win over an acknowledge in the same cycle
    always @* begin
        next_data = `PIH_DATA_RESET;
        next_valid = 1'b0;
        if (poll_take) begin
            next_data = {req_wins, 4'h0, pend_first[2:0]};
            next_valid = 1'b1;
        end else if (rd_take) begin
            if (word_select_in) begin
                next_data = imr;
            end else begin
                next_data = read_isr ? isr : irr;
            end
            next_valid = 1'b1;
        end else if (ack_second & ~ack_cascaded & (own_bus | id_match)) begin
            // Cascaded master stays off; the addressed slave answers
            next_data = {vec_base, ack_level};
            next_valid = write_strobe_low_in;
        end
    end

    always @(posedge clock_in) begin
        if (!reset_n_in) begin
            data_out_bus_out <= `PIH_DATA_RESET;
            data_out_valid_out <= 1'b0;
            buffer_ctrl_out <= 1'b1;
            buffer_ctrl_drive_low_out <= 1'b1;
            interrupt_out <= 1'b0;
        end else begin
            data_out_bus_out <= next_data;
            data_out_valid_out <= next_valid;
            // Low opens the transceivers toward the host while driving
            buffer_ctrl_out <= ~next_valid;
            buffer_ctrl_drive_low_out <= ~buffered;
            interrupt_out <= req_wins;
        end
    end

endmodule

`default_nettype wire

// ===== pih_chk.sv
// Purpose: Port checker for the interrupt host interface
// Assumes: Bound to pih_top; one clock domain, synchronous reset
// Notes: Ties valid, interrupt and drive flags to their input causes; buffer control to valid; cascade id only held stable
`timescale 1ns/1ps
`default_nettype none
module pih_chk (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic word_select_in,
    input wire logic device_select_low_in,
    input wire logic write_strobe_low_in,
    input wire logic read_strobe_low_in,
    input wire logic [7:0] data_in_bus_in,
    input wire logic acknowledge_pulse_low_in,
    input wire logic [7:0] request_lines_in,
    input wire logic [2:0] cascade_id_in,
    input wire logic master_strap_in,
    input wire logic [7:0] data_out_bus_out,
    input wire logic data_out_valid_out,
    input wire logic interrupt_out,
    input wire logic [2:0] cascade_id_out,
    input wire logic cascade_out_drive_low_out,
    input wire logic buffer_ctrl_out,
    input wire logic buffer_ctrl_drive_low_out
);
    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    // Registered valid, so the cause sits one cycle back
    valid_no_write_a: assert property (data_out_valid_out |-> $past(write_strobe_low_in))
        else $error("data valid launched from a write cycle");
    valid_cause_a: assert property (data_out_valid_out |->
        $past(!device_select_low_in && !read_strobe_low_in) ||
        ($past(acknowledge_pulse_low_in, 2) && !$past(acknowledge_pulse_low_in)))
        else $error("data valid without read or acknowledge");
    read_answer_a: assert property (!device_select_low_in && !read_strobe_low_in &&
        write_strobe_low_in |=> data_out_valid_out)
        else $error("selected read gave no data");
    deselect_quiet_a: assert property (device_select_low_in &&
        acknowledge_pulse_low_in |=> !data_out_valid_out)
        else $error("data valid while deselected");
    buffer_follow_a: assert property (buffer_ctrl_out == !data_out_valid_out)
        else $error("buffer control disagrees with data valid");
    cascade_hold_a: assert property (!cascade_out_drive_low_out &&
        $past(!cascade_out_drive_low_out) |-> $stable(cascade_id_out))
        else $error("cascade id moved while driven");
    cascade_start_a: assert property ($fell(cascade_out_drive_low_out) |->
        $past(acknowledge_pulse_low_in, 2) && !$past(acknowledge_pulse_low_in))
        else $error("cascade drive without acknowledge");
    irq_sync_a: assert property ($rose(interrupt_out) |-> $past(request_lines_in, 3) != 8'h00)
        else $error("interrupt faster than synchroniser");
    // Mode flag then drive flag: the write sits two registers back
    bufdrv_write_a: assert property (!$stable(buffer_ctrl_drive_low_out) |->
        $past(!device_select_low_in && !write_strobe_low_in, 2))
        else $error("buffer drive changed without a write");
endmodule
`default_nettype wire

// ===== pih_req_src.sv
// Purpose: Request source model for the eight request lines
// Assumes: Bench commands raise and drop for one cycle each
// Notes: A raised line stays high until the bench lets it go
`timescale 1ns/1ps
`default_nettype none
module pih_req_src (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [7:0] raise_in,
    input wire logic [7:0] drop_in,
    output logic [7:0] request_lines_out
);
    // ***************************************************************
    // Request hold
    // ***************************************************************
    // Held until the bench drops it, so an edge source never vanishes early
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            request_lines_out <= 8'h00;
        end else begin
            request_lines_out <= (request_lines_out | raise_in) & ~drop_in;
        end
    end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Purpose: Self-checking bench for the interrupt host interface
// Assumes: Single mode, then a buffered cascaded master; base byte 8'h40, strap tied to master
// Notes: Random masks and requests with fixed corner cases
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic word_select_in = 1'b0;
    logic device_select_low_in = 1'b1;
    logic write_strobe_low_in = 1'b1;
    logic read_strobe_low_in = 1'b1;
    logic [7:0] data_in_bus_in = 8'h00;
    logic acknowledge_pulse_low_in = 1'b1;
    logic master_strap_in = 1'b1;
    logic [2:0] cascade_id_in = 3'h0;
    logic [7:0] raise = 8'h00;
    logic [7:0] drop = 8'h00;
    logic [7:0] rd_val;
    logic rd_valid;
    logic [7:0] m, r, hi, rem, won;
    logic [2:0] lvl;
    int err_count = 0;
    int samples_checked = 0;
    wire [7:0] request_lines_in;
    wire [7:0] data_out_bus_out;
    wire data_out_valid_out, interrupt_out, cascade_out_drive_low_out;
    wire buffer_ctrl_out, buffer_ctrl_drive_low_out;
    wire [2:0] cascade_id_out;

    // ***************************************************************
    // Clock, partner and design
    // ***************************************************************
    always #2 clock_in = ~clock_in;
    pih_req_src src (.clock_in(clock_in), .reset_n_in(reset_n_in), .raise_in(raise),
        .drop_in(drop), .request_lines_out(request_lines_in));
    pih_top dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .word_select_in(word_select_in), .device_select_low_in(device_select_low_in),
        .write_strobe_low_in(write_strobe_low_in), .read_strobe_low_in(read_strobe_low_in),
        .data_in_bus_in(data_in_bus_in), .acknowledge_pulse_low_in(acknowledge_pulse_low_in),
        .request_lines_in(request_lines_in), .cascade_id_in(cascade_id_in),
        .master_strap_in(master_strap_in), .data_out_bus_out(data_out_bus_out),
        .data_out_valid_out(data_out_valid_out), .interrupt_out(interrupt_out),
        .cascade_id_out(cascade_id_out), .cascade_out_drive_low_out(cascade_out_drive_low_out),
        .buffer_ctrl_out(buffer_ctrl_out), .buffer_ctrl_drive_low_out(buffer_ctrl_drive_low_out));

    // Lowest index wins; level 7 when nothing is pending
    function automatic logic [2:0] lowest(input logic [7:0] v);
        lowest = 3'h7;
        for (int k = 7; k >= 0; k--) begin
            if (v[k]) lowest = k[2:0];
        end
    endfunction

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One strobe cycle; data sampled in the single cycle it stands
    task automatic access(input logic ws, input logic sel_n, input logic wr, input logic [7:0] d);
        @(posedge clock_in);
        word_select_in <= ws;
        device_select_low_in <= sel_n;
        write_strobe_low_in <= !wr;
        read_strobe_low_in <= wr;
        data_in_bus_in <= d;
        @(posedge clock_in);
        device_select_low_in <= 1'b1;
        write_strobe_low_in <= 1'b1;
        read_strobe_low_in <= 1'b1;
        #1;
        rd_val = data_out_bus_out;
        rd_valid = data_out_valid_out;
    endtask

    // Select stays high: acknowledge must not depend on it
    task automatic pulse();
        @(posedge clock_in);
        acknowledge_pulse_low_in <= 1'b0;
        @(posedge clock_in);
        acknowledge_pulse_low_in <= 1'b1;
        #1;
        rd_val = data_out_bus_out;
        rd_valid = data_out_valid_out;
    endtask

    task automatic lines(input logic [7:0] up, input logic [7:0] dn);
        @(posedge clock_in);
        raise <= up;
        drop <= dn;
        @(posedge clock_in);
        raise <= 8'h00;
        drop <= 8'h00;
        repeat (6) @(posedge clock_in);
        #1;
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ***************************************************************
    // Scenarios
    // ***************************************************************
    initial begin
        #200000;
        err_count++;
        complete_run();
    end

    initial begin
        m = $urandom(70);
        repeat (4) @(posedge clock_in);
        reset_n_in <= 1'b1;
        #1;
        check("reset data", data_out_bus_out, 8'h00);
        check("reset flags", {2'b00, data_out_valid_out, interrupt_out, cascade_out_drive_low_out,
            buffer_ctrl_out, buffer_ctrl_drive_low_out, 1'b0}, 8'h0E);
        access(0, 0, 1, 8'h12);
        access(1, 0, 1, 8'h40);
        access(0, 0, 1, 8'h0B);
        m = 8'($urandom);
        access(1, 0, 1, m);
        access(1, 1, 1, ~m);
        access(1, 1, 0, 8'h00);
        check("deselected read valid", rd_valid, 1'b0);
        access(1, 0, 0, 8'h00);
        check("mask read valid", rd_valid, 1'b1);
        check("mask read", rd_val, m);
        check("buffer ctrl", buffer_ctrl_out, 8'h00);
        for (int i = 0; i < 24; i++) begin
            m = 8'($urandom);
            r = 8'($urandom);
            if (i == 0) r = 8'h00;
            if (i == 1) begin
                m = 8'h7F;
                r = 8'h80;
            end
            cascade_id_in <= 3'($urandom);
            access(1, 0, 1, m);
            check("write valid", rd_valid, 1'b0);
            lines(r, 8'h00);
            check("irq raised", interrupt_out, |(r & ~m));
            lvl = lowest(r & ~m);
            won = (r & ~m) != 8'h00 ? 8'h01 << lvl : 8'h00;
            pulse();
            pulse();
            check("vector valid", rd_valid, 1'b1);
            check("vector", rd_val, {5'h08, lvl});
            access(0, 0, 0, 8'h00);
            check("in service", rd_val, won);
            hi = 8'($urandom) & ((8'h01 << lvl) - 8'h01) & ~r;
            lines(hi, won);
            check("irq above service", interrupt_out, |(hi & ~m));
            rem = (r | hi) & ~m & ~won;
            access(0, 0, 1, 8'h20);
            repeat (6) @(posedge clock_in);
            #1;
            check("irq after end", interrupt_out, |rem);
            lines(8'h00, 8'hFF);
        end
        access(0, 0, 1, 8'h1A);
        access(1, 0, 1, 8'h40);
        access(1, 0, 1, 8'hFB);
        lines(8'h04, 8'h00);
        check("level irq", interrupt_out, 1'b1);
        pulse();
        pulse();
        check("level vector", rd_val, 8'h42);
        access(0, 0, 1, 8'h20);
        repeat (6) @(posedge clock_in);
        #1;
        check("level irq held", interrupt_out, 1'b1);
        // Buffered cascaded master, slave on level 2; level mode keeps line 2 pending
        access(0, 0, 1, 8'h19);
        access(1, 0, 1, 8'h40);
        access(1, 0, 1, 8'h04);
        access(1, 0, 1, 8'h0C);
        pulse();
        check("cascade lines", {cascade_out_drive_low_out, buffer_ctrl_drive_low_out, 3'h0,
            cascade_id_out}, 8'h02);
        pulse();
        check("cascaded vector", {rd_valid, cascade_out_drive_low_out}, 8'h01);
        complete_run();
    end
endmodule

bind pih_top pih_chk u_chk (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .word_select_in(word_select_in), .device_select_low_in(device_select_low_in),
    .write_strobe_low_in(write_strobe_low_in), .read_strobe_low_in(read_strobe_low_in),
    .data_in_bus_in(data_in_bus_in), .acknowledge_pulse_low_in(acknowledge_pulse_low_in),
    .request_lines_in(request_lines_in), .cascade_id_in(cascade_id_in),
    .master_strap_in(master_strap_in), .data_out_bus_out(data_out_bus_out),
    .data_out_valid_out(data_out_valid_out), .interrupt_out(interrupt_out),
    .cascade_id_out(cascade_id_out), .cascade_out_drive_low_out(cascade_out_drive_low_out),
    .buffer_ctrl_out(buffer_ctrl_out), .buffer_ctrl_drive_low_out(buffer_ctrl_drive_low_out));
`default_nettype wire
